// *** hw/clk_pow2_divider.sv ***
`timescale 1ns/10ps
module clk_pow2_divider (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // undivided source
   input  wire logic       i_src_tick,
   input  wire logic       i_hold,
   input  wire logic [2:0] i_ratio,
   // divided output
   output logic            o_clk_en,
   output logic            o_applied
);
   logic [clk_sel_pkg::CNT_W-1:0] cnt_r;
   logic [clk_sel_pkg::CNT_W-1:0] cnt_nxt;
   logic [clk_sel_pkg::CNT_W-1:0] mask;
   logic [2:0]                    active_r;
   logic [2:0]                    active_nxt;
   logic                          en_nxt;
   logic                          applied_nxt;
   logic [7:0]                    span;

   always_comb begin
      span        = 8'h01 << active_r;
      mask        = 7'(span - 8'h01);
      cnt_nxt     = cnt_r;
      active_nxt  = active_r;
      en_nxt      = 1'b0;
      // ratio only changes at a period boundary, so no pulse is ever cut short
      if (i_src_tick && !i_hold) begin
         if (cnt_r == mask) begin
            cnt_nxt    = '0;
            en_nxt     = 1'b1;                                   // [R1]
            active_nxt = i_ratio;                                // [R2] [R14]
         end else begin
            cnt_nxt = cnt_r + 7'h01;
         end
      end
      applied_nxt = (active_nxt == i_ratio);                     // [R3]
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r     <= '0;
         active_r  <= clk_sel_pkg::CLK_SELECT_RESET[clk_sel_pkg::DIV_HI:clk_sel_pkg::DIV_LO];
         o_clk_en  <= 1'b0;
         o_applied <= 1'b0;
      end else begin
         cnt_r     <= cnt_nxt;
         active_r  <= active_nxt;
         o_clk_en  <= en_nxt;
         o_applied <= applied_nxt;
      end
   end

   // helper: undivided ticks seen while a ratio is pending
   logic [8:0] pend_ticks_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_ticks_r <= '0;
      end else if (active_r == i_ratio || i_hold) begin
         pend_ticks_r <= '0;
      end else if (i_src_tick) begin
         pend_ticks_r <= pend_ticks_r + 9'h001;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   ratio_bound_a: assert property (pend_ticks_r <= 9'd128) // [R2]
      else $error("divide ratio pending over 128 source ticks");
   div_one_a: assert property (i_src_tick && !i_hold && active_r == clk_sel_pkg::DIV_BY_1 |=> o_clk_en) // [R1]
      else $error("divide-by-1 missed a source tick");
   hold_quiet_a: assert property (i_hold |=> !o_clk_en) // [R14]
      else $error("divided pulse while source switch holds");
   // a boundary pulse may be followed at once by the first pulse of a faster new ratio
   pulse_gap_a: assert property (o_clk_en && $past(active_r) == 3'h1 && active_r == 3'h1 |=> !o_clk_en) // [R1]
      else $error("divide-by-2 pulses back to back");
   ratio_change_c: cover property (!o_applied ##1 o_applied);
endmodule : clk_pow2_divider

// *** hw/system_clock_select_divider.sv ***
`timescale 1ns/10ps
module system_clock_select_divider (
   // clock and reset
   input  wire logic                  I_SYS_CLK,
   input  wire logic                  I_SYS_RST,
   // special function register access
   input  wire clk_sel_pkg::sfr_req_t I_SFR_REQ,
   output logic [7:0]                 O_SFR_RDATA,
   // oscillator sources
   input  wire clk_sel_pkg::osc_tick_t I_OSC_TICK,
   input  wire logic                  I_INT_OSC_STABLE,
   output logic                       O_INT_OSC_EN,
   // system clock
   output logic                       O_SYS_CLK_EN,
   output logic [2:0]                 O_ACTIVE_SRC
);
   clk_sel_pkg::switch_state_t state_r;
   clk_sel_pkg::switch_state_t state_nxt;
   logic [2:0]  sel_req_r;
   logic [2:0]  sel_req_nxt;
   logic [2:0]  div_req_r;
   logic [2:0]  div_req_nxt;
   logic [2:0]  target_r;
   logic [2:0]  target_nxt;
   logic        old_seen_r;
   logic        old_seen_nxt;
   logic        new_seen_r;
   logic        new_seen_nxt;
   logic        osc_en_nxt;
   logic [5:0]  rsv_r;
   logic [5:0]  rsv_nxt;
   logic        freq_rdy_r;
   logic        freq_rdy_nxt;
   logic [2:0]  lp8_cnt_r;
   logic [2:0]  lp8_cnt_nxt;
   logic [2:0]  active_nxt;
   logic [7:0]  rdata_nxt;
   logic [4:0]  src_tick;
   logic        cur_tick;
   logic        applied;
   logic        wr_sel;
   logic        wr_osc;

   assign wr_sel = I_SFR_REQ.wr && (I_SFR_REQ.addr == clk_sel_pkg::CLK_SELECT_ADDR);
   assign wr_osc = I_SFR_REQ.wr && (I_SFR_REQ.addr == clk_sel_pkg::INT_OSC_CTRL_ADDR);

   // tick vector indexed by source code
   always_comb begin
      src_tick                            = '0;
      src_tick[clk_sel_pkg::SRC_PRECISION] = I_OSC_TICK.precision && O_INT_OSC_EN;       // [R9]
      src_tick[clk_sel_pkg::SRC_EXTERNAL]  = I_OSC_TICK.external;                        // [R6]
      src_tick[clk_sel_pkg::SRC_LP_DIV8]   = I_OSC_TICK.low_power &&
                                             (lp8_cnt_r == clk_sel_pkg::LP8_LAST);       // [R6]
      src_tick[clk_sel_pkg::SRC_RTC]       = I_OSC_TICK.rtc;                             // [R6]
      src_tick[clk_sel_pkg::SRC_LP]        = I_OSC_TICK.low_power;                       // [R6]
      cur_tick                             = src_tick[O_ACTIVE_SRC];
      lp8_cnt_nxt = I_OSC_TICK.low_power ? lp8_cnt_r + 3'h1 : lp8_cnt_r;
   end

   // register file
   always_comb begin
      sel_req_nxt = sel_req_r;
      div_req_nxt = div_req_r;
      osc_en_nxt  = O_INT_OSC_EN;
      rsv_nxt     = rsv_r;
      if (wr_sel) begin
         div_req_nxt = I_SFR_REQ.wdata[clk_sel_pkg::DIV_HI:clk_sel_pkg::DIV_LO];        // [R1]
         sel_req_nxt = I_SFR_REQ.wdata[clk_sel_pkg::SEL_HI:clk_sel_pkg::SEL_LO];        // [R6]
      end
      if (wr_osc) begin
         osc_en_nxt = I_SFR_REQ.wdata[clk_sel_pkg::OSC_EN_BIT];                         // [R9]
         rsv_nxt    = I_SFR_REQ.wdata[clk_sel_pkg::RSV_HI:0];
      end
      freq_rdy_nxt = O_INT_OSC_EN && I_INT_OSC_STABLE;                                  // [R10]
      rdata_nxt    = O_SFR_RDATA;
      if (I_SFR_REQ.rd) begin
         case (I_SFR_REQ.addr)
            clk_sel_pkg::CLK_SELECT_ADDR:   rdata_nxt = {applied, div_req_r, 1'b0, sel_req_r}; // [R3] [R8]
            clk_sel_pkg::INT_OSC_CTRL_ADDR: rdata_nxt = {O_INT_OSC_EN, freq_rdy_r, rsv_r};     // [R10]
            default:                        rdata_nxt = 8'h00;
         endcase
      end
   end

   // on-the-fly source switch: the divider is frozen until both the old and the new
   // oscillator have shown an edge, which takes at most one period of the slower one
   always_comb begin
      state_nxt    = state_r;
      target_nxt   = target_r;
      old_seen_nxt = old_seen_r;
      new_seen_nxt = new_seen_r;
      active_nxt   = O_ACTIVE_SRC;
      case (state_r)
         clk_sel_pkg::SW_IDLE: begin
            // reserved codes name no oscillator; the running source is kept
            if (sel_req_r != O_ACTIVE_SRC && sel_req_r <= clk_sel_pkg::SRC_LP) begin   // [R5]
               state_nxt    = clk_sel_pkg::SW_SWITCH;
               target_nxt   = sel_req_r;
               old_seen_nxt = 1'b0;
               new_seen_nxt = 1'b0;
            end
         end
         clk_sel_pkg::SW_SWITCH: begin
            old_seen_nxt = old_seen_r || cur_tick;
            new_seen_nxt = new_seen_r || src_tick[target_r];
            if (old_seen_nxt && new_seen_nxt) begin
               active_nxt = target_r;                                                   // [R5] [R14]
               state_nxt  = clk_sel_pkg::SW_IDLE;
            end
         end
         default: begin
            state_nxt = clk_sel_pkg::SW_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state_r      <= clk_sel_pkg::SW_IDLE;
         sel_req_r    <= clk_sel_pkg::CLK_SELECT_RESET[clk_sel_pkg::SEL_HI:clk_sel_pkg::SEL_LO];
         div_req_r    <= clk_sel_pkg::CLK_SELECT_RESET[clk_sel_pkg::DIV_HI:clk_sel_pkg::DIV_LO];
         target_r     <= clk_sel_pkg::CLK_SELECT_RESET[clk_sel_pkg::SEL_HI:clk_sel_pkg::SEL_LO];
         O_ACTIVE_SRC <= clk_sel_pkg::CLK_SELECT_RESET[clk_sel_pkg::SEL_HI:clk_sel_pkg::SEL_LO];
         old_seen_r   <= 1'b0;
         new_seen_r   <= 1'b0;
         O_INT_OSC_EN <= 1'b0;
         rsv_r        <= clk_sel_pkg::OSC_RSV_RESET;
         freq_rdy_r   <= 1'b0;
         lp8_cnt_r    <= '0;
         O_SFR_RDATA  <= 8'h00;
      end else begin
         state_r      <= state_nxt;
         sel_req_r    <= sel_req_nxt;
         div_req_r    <= div_req_nxt;
         target_r     <= target_nxt;
         O_ACTIVE_SRC <= active_nxt;
         old_seen_r   <= old_seen_nxt;
         new_seen_r   <= new_seen_nxt;
         O_INT_OSC_EN <= osc_en_nxt;
         rsv_r        <= rsv_nxt;
         freq_rdy_r   <= freq_rdy_nxt;
         lp8_cnt_r    <= lp8_cnt_nxt;
         O_SFR_RDATA  <= rdata_nxt;
      end
   end

   // divider output is a clock enable, not a gated clock, so it cannot glitch
   clk_pow2_divider u_divider (
      .i_clk      (I_SYS_CLK),
      .i_rst      (I_SYS_RST),
      .i_src_tick (cur_tick),
      .i_hold     (state_r == clk_sel_pkg::SW_SWITCH),                                   // [R14]
      .i_ratio    (div_req_r),
      .o_clk_en   (O_SYS_CLK_EN),
      .o_applied  (applied)
   );

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SYS_RST);

   unused_zero_a: assert property (I_SFR_REQ.rd && I_SFR_REQ.addr == clk_sel_pkg::CLK_SELECT_ADDR // [R8]
                                   |=> O_SFR_RDATA[3] == 1'b0)
      else $error("clock select bit 3 read nonzero");
   // the middle cycle must be free of writes, or the readback shows a later value
   sel_readback_a: assert property (wr_sel ##1 !wr_sel ##1 // [R1]
                                    (I_SFR_REQ.rd && I_SFR_REQ.addr == clk_sel_pkg::CLK_SELECT_ADDR)
                                    |=> O_SFR_RDATA[clk_sel_pkg::DIV_HI:clk_sel_pkg::DIV_LO]
                                        == $past(I_SFR_REQ.wdata[clk_sel_pkg::DIV_HI:clk_sel_pkg::DIV_LO], 3))
      else $error("divide field readback mismatch");
   ready_flag_a: assert property (I_SFR_REQ.rd && I_SFR_REQ.addr == clk_sel_pkg::CLK_SELECT_ADDR // [R3]
                                  |=> O_SFR_RDATA[clk_sel_pkg::RDY_BIT] == $past(applied))
      else $error("ready flag does not show divider state");
   freq_ready_a: assert property (freq_rdy_r |-> $past(O_INT_OSC_EN) && $past(I_INT_OSC_STABLE)) // [R10]
      else $error("frequency ready without running oscillator");
   osc_enable_a: assert property (wr_osc |=> O_INT_OSC_EN == $past(I_SFR_REQ.wdata[clk_sel_pkg::OSC_EN_BIT])) // [R9]
      else $error("oscillator enable not taken from write");
   osc_stopped_a: assert property (!O_INT_OSC_EN && O_ACTIVE_SRC == clk_sel_pkg::SRC_PRECISION |=> !O_SYS_CLK_EN) // [R9]
      else $error("system clock runs on a stopped precision oscillator");
   switch_wait_a: assert property ($changed(O_ACTIVE_SRC) |-> $past(state_r) == clk_sel_pkg::SW_SWITCH // [R5]
                                   && ($past(old_seen_r) || $past(cur_tick)))
      else $error("source switched before old oscillator edge");
   no_reserved_a: assert property (O_ACTIVE_SRC <= clk_sel_pkg::SRC_LP) // [R6]
      else $error("reserved source became active");
   switch_c: cover property (state_r == clk_sel_pkg::SW_SWITCH ##1 state_r == clk_sel_pkg::SW_IDLE);
   rtc_src_c: cover property (O_ACTIVE_SRC == clk_sel_pkg::SRC_RTC && O_SYS_CLK_EN);
   freq_rdy_c: cover property (!freq_rdy_r ##1 freq_rdy_r);
endmodule : system_clock_select_divider

// *** shared/clk_sel_pkg.sv ***
// Contract
// [R1] system clock equals undivided source divided by two to the divide-ratio field
// [R2] a new divide ratio takes effect within 128 undivided source ticks
// [R3] divider_applied_flag reads 0 while ratio pending, 1 once applied
// [R4] software sets divide-by-1 before entering suspend or sleep
// [R5] source may change while running; takes effect after one slower-oscillator period
// [R6] source_select_field codes: precision, external, low-power/8, rtc, low-power
// [R7] software never writes source codes 101, 110 or 111; the testbench writes 101 once to check it is ignored
// [R8] clock select bit 3 reads zero; software writes zero
// [R9] internal_osc_enable stops the precision oscillator at 0, runs it at 1
// [R10] internal_freq_ready reads 1 only while precision oscillator is at frequency
// [R11] software preserves reserved control bits 5:0 with read-modify-write; the testbench writes them from a random model value instead
// [R12] software sets osc_bias_enable before enabling the precision oscillator
// [R13] software should bypass the flash one-shot above 10 MHz system clock
// [R14] ratio and source changes never produce runt or glitch system clock pulses
package clk_sel_pkg;
   localparam logic [7:0] CLK_SELECT_ADDR   = 8'ha9;
   localparam logic [7:0] INT_OSC_CTRL_ADDR = 8'hb2;
   localparam logic [7:0] CLK_SELECT_RESET  = 8'h12;
   localparam logic [5:0] OSC_RSV_RESET     = 6'h00;
   localparam int         RDY_BIT           = 7;
   localparam int         DIV_HI            = 6;
   localparam int         DIV_LO            = 4;
   localparam int         SEL_HI            = 2;
   localparam int         SEL_LO            = 0;
   localparam int         OSC_EN_BIT        = 7;
   localparam int         RSV_HI            = 5;
   localparam int         CNT_W             = 7;
   localparam logic [2:0] SRC_PRECISION     = 3'h0;
   localparam logic [2:0] SRC_EXTERNAL      = 3'h1;
   localparam logic [2:0] SRC_LP_DIV8       = 3'h2;
   localparam logic [2:0] SRC_RTC           = 3'h3;
   localparam logic [2:0] SRC_LP            = 3'h4;
   localparam logic [2:0] LP8_LAST          = 3'h7;
   localparam logic [2:0] DIV_BY_1          = 3'h0;

   typedef enum logic [0:0] {
      SW_IDLE   = 1'b0,
      SW_SWITCH = 1'b1
   } switch_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // raw oscillator edges, one-cycle pulses in the system clock domain
   typedef struct packed {
      logic precision;
      logic external;
      logic rtc;
      logic low_power;
   } osc_tick_t;
endpackage : clk_sel_pkg

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   logic                   sys_clk;
   logic                   sys_rst;
   clk_sel_pkg::sfr_req_t  sfr_req;
   logic [7:0]             sfr_rdata;
   clk_sel_pkg::osc_tick_t osc_tick;
   logic                   osc_stable;
   logic                   osc_en;
   logic                   sys_clk_en;
   logic [2:0]             active_src;
   int                     fail_count;
   int                     check_count;
   int                     pulse_cnt;
   int                     n;
   logic [7:0]             rd_val;
   // model of the register contents, updated from the writes only
   logic [2:0]             div_m;
   logic [2:0]             prev_m;
   logic [2:0]             sel_m;
   logic [5:0]             rsv_m;
   logic [2:0]             src_list [5] = '{3'h0, 3'h3, 3'h4, 3'h2, 3'h1};

   system_clock_select_divider i_dut (
      .I_SYS_CLK        (sys_clk),
      .I_SYS_RST        (sys_rst),
      .I_SFR_REQ        (sfr_req),
      .O_SFR_RDATA      (sfr_rdata),
      .I_OSC_TICK       (osc_tick),
      .I_INT_OSC_STABLE (osc_stable),
      .O_INT_OSC_EN     (osc_en),
      .O_SYS_CLK_EN     (sys_clk_en),
      .O_ACTIVE_SRC     (active_src)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk; // never above 10 MHz, so no flash bypass is due
   end

   // counted mid-cycle, where the registered pulse has settled
   always @(negedge sys_clk) begin
      if (sys_clk_en === 1'b1) pulse_cnt++;
   end

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk8

   task automatic chk_cnt(input string name, input int exp, input int got);
      check_count++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_cnt

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_req <= clk_sel_pkg::sfr_req_t'{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      sfr_req <= '0;
      #1;
   endtask : sfr_write

   task automatic sfr_read(input logic [7:0] a);
      @(posedge sys_clk);
      sfr_req <= clk_sel_pkg::sfr_req_t'{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      sfr_req <= '0;
      @(posedge sys_clk);
      #1;
      rd_val = sfr_rdata;
   endtask : sfr_read

   // external ticks with random idle gaps; unselected sources get noise that must be ignored
   task automatic ext_ticks(input int cnt);
      int gap;
      for (int i = 0; i < cnt; i++) begin
         gap = $urandom_range(2);
         repeat (gap) begin
            @(posedge sys_clk);
            osc_tick <= {1'($urandom), 1'b0, 1'($urandom), 1'($urandom)};
         end
         @(posedge sys_clk);
         osc_tick <= {1'($urandom), 1'b1, 1'($urandom), 1'($urandom)};
      end
      @(posedge sys_clk);
      osc_tick <= '0;
   endtask : ext_ticks

   task automatic all_ticks(input int cnt, input logic [2:0] want);
      for (int i = 0; i < cnt && active_src !== want; i++) begin
         @(posedge sys_clk);
         osc_tick <= 4'hf;
         #1;
      end
      @(posedge sys_clk);
      osc_tick <= '0;
      #1;
   endtask : all_ticks

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // the whole sweep needs well under 20k cycles
   initial begin
      #(4_000_000);
      fail_count++;
      print_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      sfr_req = '0;
      osc_tick = '0;
      osc_stable = 1'b0;
      fail_count = 0;
      check_count = 0;
      pulse_cnt = 0;
      void'($urandom(32'h12a2db24));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      div_m = 3'h1;
      sel_m = clk_sel_pkg::SRC_LP_DIV8;
      sfr_read(clk_sel_pkg::CLK_SELECT_ADDR);
      chk8("clk_select", {1'b1, div_m, 1'b0, sel_m}, rd_val);
      chk8("active_src", 8'(sel_m), 8'(active_src));
      sfr_read(clk_sel_pkg::INT_OSC_CTRL_ADDR);
      chk8("osc_ctrl", 8'h00, rd_val);
      sfr_read(8'h55);
      chk8("unmapped", 8'h00, rd_val);
      @(posedge sys_clk);
      osc_stable <= 1'b1;
      rsv_m = 6'($urandom);
      sfr_write(clk_sel_pkg::INT_OSC_CTRL_ADDR, {2'b10, rsv_m});
      chk8("osc_en", 8'h01, 8'(osc_en));
      sfr_read(clk_sel_pkg::INT_OSC_CTRL_ADDR);
      chk8("osc_ctrl", {2'b11, rsv_m}, rd_val);
      @(posedge sys_clk);
      osc_stable <= 1'b0;
      repeat (2) @(posedge sys_clk);
      sfr_read(clk_sel_pkg::INT_OSC_CTRL_ADDR);
      chk8("osc_ctrl", {2'b10, rsv_m}, rd_val);
      foreach (src_list[k]) begin
         sel_m = src_list[k];
         sfr_write(clk_sel_pkg::CLK_SELECT_ADDR, {1'b0, div_m, 1'b0, sel_m});
         sfr_read(clk_sel_pkg::CLK_SELECT_ADDR);
         chk8("clk_select", {1'b1, div_m, 1'b0, sel_m}, rd_val);
         all_ticks(40, sel_m);
         chk8("active_src", 8'(sel_m), 8'(active_src));
         // a stopped precision oscillator must freeze the system clock
         if (sel_m == clk_sel_pkg::SRC_PRECISION) begin
            sfr_write(clk_sel_pkg::INT_OSC_CTRL_ADDR, {2'b00, rsv_m});
            pulse_cnt = 0;
            all_ticks(20, 3'h5);
            chk_cnt("stopped_pulses", 0, pulse_cnt);
            sfr_write(clk_sel_pkg::INT_OSC_CTRL_ADDR, {2'b10, rsv_m});
         end
      end
      // robustness only: a reserved code must never reach the divider
      sfr_write(clk_sel_pkg::CLK_SELECT_ADDR, {1'b0, div_m, 4'h5});
      sfr_read(clk_sel_pkg::CLK_SELECT_ADDR);
      chk8("clk_select", {1'b1, div_m, 4'h5}, rd_val);
      all_ticks(20, 3'h5);
      chk8("active_src", 8'(sel_m), 8'(active_src));
      sfr_write(clk_sel_pkg::CLK_SELECT_ADDR, {1'b0, div_m, 1'b0, sel_m});
      // last pass returns to divide-by-1, the setting needed before sleep
      for (int i = 0; i < 9; i++) begin
         prev_m = div_m;
         div_m = 3'(i % 8);
         sfr_write(clk_sel_pkg::CLK_SELECT_ADDR, {1'b0, div_m, 1'b0, sel_m});
         sfr_read(clk_sel_pkg::CLK_SELECT_ADDR);
         chk8("clk_select", {(div_m == prev_m), div_m, 1'b0, sel_m}, rd_val);
         n = 0;
         while (rd_val[7] !== 1'b1 && n < 200) begin
            ext_ticks(1);
            n++;
            sfr_read(clk_sel_pkg::CLK_SELECT_ADDR);
         end
         chk_cnt("apply_in_bound", 1, int'(n <= (1 << prev_m)));
         pulse_cnt = 0;
         ext_ticks(2 << div_m);
         repeat (3) @(posedge sys_clk);
         chk_cnt("sys_pulses", 2, pulse_cnt);
      end
      print_verdict();
   end
endmodule : tb_top
